// ### design/aid_datapath.sv
// alu datapath top: execute stage, status flags, i/o bit sequencer, apb slave
// Functional notes
// RULE_01: add two registers, optionally plus carry, store the sum and update z c n v h in one clock.
// RULE_02: subtract source from destination, optionally minus carry, store it and update z c n v h in one clock.
// RULE_03: subtract an immediate from the destination, store it and update z c n v h in one clock.
// RULE_04: subtract an immediate and the carry from the destination, store it and update z c n v h in one clock.
// RULE_05: and the destination with a register or immediate, store it, update only z n v, in one clock.
// RULE_06: or with register or immediate, or xor with register, store it, update only z n v, in one clock.
// RULE_07: set bits ors a mask into the destination, keeps other bits, updates z n v in one clock.
// RULE_08: clear bits ands the destination with all-ones minus the mask and updates z n v in one clock.
// RULE_09: test ands a register with itself, leaving it unchanged, and sets z n v in one clock.
// RULE_10: certain i/o flags clear when a one is written to them and keep their value on a zero.
// RULE_11: i/o bit set and clear only reach i/o indices 0x00 to 0x1f.
// RULE_12: i/o bit set and clear rewrite the whole register, so a set clear-on-one flag is cleared.
// RULE_13: software writes zero to reserved bits of i/o registers it touches.
// RULE_14: software never writes a reserved i/o address.
// RULE_15: status flags are i t h s v n z c from msb down; the alu updates c z n v h.
`timescale 1ns/1ps
module aid_datapath #(
	parameter int unsigned REG_COUNT = aid_pkg::REG_COUNT
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	// decoder side
	input  wire logic        opValid,
	output logic             opReady,
	input  wire logic [3:0]  opCode,
	input  wire logic [4:0]  dstIdx,
	input  wire logic [4:0]  srcIdx,
	input  wire logic [7:0]  immValue,
	input  wire logic [5:0]  ioIdx,
	input  wire logic [2:0]  bitSel,
	output logic             resultValid,
	output logic [4:0]       resultDst,
	output logic [7:0]       resultData,
	output logic             ioRefused,
	output logic [7:0]       statusFlags,
	// i/o space side
	input  wire logic [7:0]  eventIn,
	output logic [7:0]       scratchOut,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	if (REG_COUNT != aid_pkg::REG_COUNT) begin : g_chk
		$error("aid_datapath: register index is five bits wide");
	end

	aid_pkg::aid_state_t state_reg;
	aid_pkg::aid_state_t state_next;
	aid_pkg::aid_op_t    exOp_reg;
	logic       exValid_reg;
	logic [4:0] exDst_reg;
	logic [7:0] exImm_reg;
	logic [7:0] status_reg;
	logic [7:0] flagsNext;
	logic [7:0] opA;
	logic [7:0] opSrc;
	logic [7:0] opB;
	logic [7:0] aluRes;
	logic [10:0] arith;
	logic       resultValid_reg;
	logic [4:0] resultDst_reg;
	logic [7:0] resultData_reg;
	logic       ioRefused_reg;
	logic [4:0] rmwIdx_reg;
	logic [7:0] rmwData_reg;
	logic [7:0] ioRdBit;
	logic [7:0] ioRdApb;
	logic [31:0] prdata_reg;
	logic       accept;
	logic       isBit;
	logic       bitOk;
	logic [5:0] apbIdx;
	logic       apbMapped;
	logic       apbWrite;
	logic       ioWrEn;
	logic [5:0] ioWrIdx;
	logic [7:0] ioWrData;

	// arithmetic with flags packed as {v, h, c, result}
	function automatic logic [10:0] aluArith(input logic [7:0] a, b, input logic cin, sub);
		logic [7:0] r;
		logic       h;
		logic       c;
		logic       v;
		r = sub ? 8'(a - b - {7'h00, cin}) : 8'(a + b + {7'h00, cin});
		if (sub) begin
			h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
			c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
			v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		end else begin
			h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
			c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
			v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
		end
		aluArith = {v, h, c, r};
	endfunction

	// immediate forms and the mask forms take the constant as second operand
	function automatic logic isImm(input aid_pkg::aid_op_t op);
		isImm = op inside {aid_pkg::OP_SUBTRACT_IMMEDIATE, aid_pkg::OP_SUBTRACT_IMMEDIATE_WITH_CARRY, aid_pkg::OP_AND_IMMEDIATE, aid_pkg::OP_ORI,
			aid_pkg::OP_SETM, aid_pkg::OP_CLRM};
	endfunction

	assign isBit  = opCode == aid_pkg::OP_IOSET || opCode == aid_pkg::OP_IOCLR;
	assign bitOk  = ioIdx <= aid_pkg::IO_BIT_LAST; // [RULE_11]
	assign accept = opValid && opReady;

	// operands come straight out of the register file's read register
	aid_regfile #(
		.WIDTH (aid_pkg::DATA_W),
		.DEPTH (REG_COUNT),
		.AW    (aid_pkg::REG_AW)
	) u_regs (
		.clk     (clk),
		.wrEn    (exValid_reg),
		.wrAddr  (exDst_reg),
		.wrData  (aluRes),
		.rdAddrA (dstIdx),
		.rdAddrB (srcIdx),
		.rdDataA (opA),
		.rdDataB (opSrc)
	);

	// issue stage: capture the op while the register file reads
	always_ff @(posedge clk) begin
		if (!nrst) begin
			exValid_reg <= 1'b0;
			exOp_reg    <= aid_pkg::OP_ADD;
			exDst_reg   <= 5'h00;
			exImm_reg   <= 8'h00;
		end else begin
			exValid_reg <= accept && !isBit;
			exOp_reg    <= aid_pkg::aid_op_t'(opCode);
			exDst_reg   <= dstIdx;
			exImm_reg   <= immValue;
		end
	end

	// second operand select; the clear mask is all-ones minus the constant
	always_comb begin
		if (exOp_reg == aid_pkg::OP_CLRM) begin
			opB = aid_pkg::ALL_ONES - exImm_reg; // [RULE_08]
		end else if (exOp_reg == aid_pkg::OP_TEST) begin
			opB = opA; // [RULE_09]
		end else if (isImm(exOp_reg)) begin
			opB = exImm_reg; // [RULE_03]
		end else begin
			opB = opSrc;
		end
	end

	// execute: result and flags settle within the single execute cycle
	always_comb begin
		arith     = aluArith(opA, opB, 1'b0, 1'b0);
		aluRes    = opA;
		flagsNext = status_reg;
		case (exOp_reg)
			aid_pkg::OP_ADD, aid_pkg::OP_ADC: begin
				arith = aluArith(opA, opB, exOp_reg == aid_pkg::OP_ADC && status_reg[aid_pkg::FLAG_C], 1'b0); // [RULE_01]
			end
			aid_pkg::OP_SUB, aid_pkg::OP_SUBTRACT_IMMEDIATE: begin
				arith = aluArith(opA, opB, 1'b0, 1'b1); // [RULE_02] [RULE_03]
			end
			aid_pkg::OP_SBC, aid_pkg::OP_SUBTRACT_IMMEDIATE_WITH_CARRY: begin
				arith = aluArith(opA, opB, status_reg[aid_pkg::FLAG_C], 1'b1); // [RULE_02] [RULE_04]
			end
			aid_pkg::OP_AND, aid_pkg::OP_AND_IMMEDIATE, aid_pkg::OP_CLRM, aid_pkg::OP_TEST: begin
				aluRes = opA & opB; // [RULE_05] [RULE_08] [RULE_09]
			end
			aid_pkg::OP_OR, aid_pkg::OP_ORI, aid_pkg::OP_SETM: begin
				aluRes = opA | opB; // [RULE_06] [RULE_07]
			end
			aid_pkg::OP_EOR: begin
				aluRes = opA ^ opB; // [RULE_06]
			end
			default: begin
				aluRes = opA;
			end
		endcase
		if (exOp_reg <= aid_pkg::OP_SUBTRACT_IMMEDIATE_WITH_CARRY) begin
			aluRes                     = arith[7:0];
			flagsNext[aid_pkg::FLAG_C] = arith[8]; // [RULE_15]
			flagsNext[aid_pkg::FLAG_H] = arith[9];
			flagsNext[aid_pkg::FLAG_V] = arith[10];
		end else begin
			flagsNext[aid_pkg::FLAG_V] = 1'b0; // [RULE_05] [RULE_06]
		end
		flagsNext[aid_pkg::FLAG_N] = aluRes[7];
		flagsNext[aid_pkg::FLAG_Z] = aluRes == 8'h00;
	end

	// status flags: the executing op wins over a software write in the same cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			status_reg <= aid_pkg::STATUS_RST;
		end else if (exValid_reg) begin
			status_reg <= flagsNext; // [RULE_15]
		end else if (apbWrite && apbIdx == aid_pkg::STATUS_IDX) begin
			status_reg <= pwdata[7:0];
		end
	end

	// result report to the decoder, registered at the same edge as write-back
	always_ff @(posedge clk) begin
		if (!nrst) begin
			resultValid_reg <= 1'b0;
			resultDst_reg   <= 5'h00;
			resultData_reg  <= 8'h00;
		end else begin
			resultValid_reg <= exValid_reg;
			// data stands until the next result, not only for the valid pulse
			if (exValid_reg) begin
				resultDst_reg  <= exDst_reg;
				resultData_reg <= aluRes;
			end
		end
	end

	// bit sequencer: read in the accept cycle, rewrite the whole byte next cycle
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			aid_pkg::ST_IDLE: begin
				if (accept && isBit && bitOk) begin
					state_next = aid_pkg::ST_WRITE; // [RULE_12]
				end
			end
			aid_pkg::ST_WRITE: begin
				state_next = aid_pkg::ST_IDLE;
			end
			default: begin
				state_next = aid_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg <= aid_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// modified byte keeps every other bit as read, flags set included
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rmwIdx_reg    <= 5'h00;
			rmwData_reg   <= 8'h00;
			ioRefused_reg <= 1'b0;
		end else begin
			ioRefused_reg <= accept && isBit && !bitOk; // [RULE_11]
			if (accept && isBit && bitOk) begin
				rmwIdx_reg  <= ioIdx[4:0];
				rmwData_reg <= (opCode == aid_pkg::OP_IOSET) ? (ioRdBit | (8'h01 << bitSel))
					: (ioRdBit & ~(8'h01 << bitSel)); // [RULE_12]
			end
		end
	end

	// one op at a time while the rewrite holds the i/o write port
	assign opReady = state_reg == aid_pkg::ST_IDLE;

	// apb decode: word index, aligned, only implemented registers answer cleanly
	assign apbIdx    = paddr[7:2];
	assign apbMapped = paddr[1:0] == 2'b00 && (apbIdx == aid_pkg::STATUS_IDX
		|| apbIdx == aid_pkg::EVENT_IDX || apbIdx == aid_pkg::SCRATCH_IDX);
	assign pready    = psel && penable && state_reg != aid_pkg::ST_WRITE;
	assign pslverr   = pready && !apbMapped;
	assign apbWrite  = pready && pwrite && apbMapped;

	// i/o write port: the rewrite has priority, apb is stalled meanwhile
	assign ioWrEn   = state_reg == aid_pkg::ST_WRITE || (apbWrite && apbIdx != aid_pkg::STATUS_IDX);
	assign ioWrIdx  = state_reg == aid_pkg::ST_WRITE ? {1'b0, rmwIdx_reg} : apbIdx;
	assign ioWrData = state_reg == aid_pkg::ST_WRITE ? rmwData_reg : pwdata[7:0];

	aid_io_space u_io (
		.clk        (clk),
		.nrst       (nrst),
		.wrEn       (ioWrEn),
		.wrIdx      (ioWrIdx),
		.wrData     (ioWrData),
		.eventIn    (eventIn),
		.rdIdxA     (ioIdx),
		.rdIdxB     (apbIdx),
		.rdDataA    (ioRdBit),
		.rdDataB    (ioRdApb),
		.scratchOut (scratchOut)
	);

	// read data is captured every waiting cycle so the sampling edge sees it
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !pready) begin
			prdata_reg <= {24'h00_0000, (apbIdx == aid_pkg::STATUS_IDX) ? status_reg : ioRdApb};
		end
	end

	assign prdata      = prdata_reg;
	assign resultValid = resultValid_reg;
	assign resultDst   = resultDst_reg;
	assign resultData  = resultData_reg;
	assign ioRefused   = ioRefused_reg;
	assign statusFlags = status_reg;

	// checks on the datapath
	add_sum_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_01]
		exValid_reg && exOp_reg == aid_pkg::OP_ADC |=> resultData == 8'($past(opA) + $past(opSrc)
		+ {7'h00, $past(status_reg[aid_pkg::FLAG_C])})) else $error("add with carry sum wrong");
	sub_borrow_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_02]
		exValid_reg && exOp_reg == aid_pkg::OP_SUB |=> statusFlags[aid_pkg::FLAG_C] == ($past(opA) < $past(opSrc))
		&& resultData == 8'($past(opA) - $past(opSrc))) else $error("subtract borrow or result wrong");
	subtract_immediate_result_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_03]
		accept && opCode == aid_pkg::OP_SUBTRACT_IMMEDIATE ##1 1'b1 |=> resultData == 8'($past(opA) - $past(immValue, 2)))
		else $error("subtract immediate result wrong");
	subtract_immediate_with_carry_result_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_04]
		exValid_reg && exOp_reg == aid_pkg::OP_SUBTRACT_IMMEDIATE_WITH_CARRY |=> resultData == 8'($past(opA) - $past(exImm_reg)
		- {7'h00, $past(status_reg[aid_pkg::FLAG_C])})) else $error("subtract immediate with carry wrong");
	logic_keeps_ch_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_05]
		exValid_reg && exOp_reg inside {aid_pkg::OP_AND, aid_pkg::OP_AND_IMMEDIATE} |=> !statusFlags[aid_pkg::FLAG_V]
		&& statusFlags[aid_pkg::FLAG_C] == $past(status_reg[aid_pkg::FLAG_C])
		&& statusFlags[aid_pkg::FLAG_H] == $past(status_reg[aid_pkg::FLAG_H])) else $error("and touched c or h");
	xor_result_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_06]
		exValid_reg && exOp_reg == aid_pkg::OP_EOR |=> resultData == ($past(opA) ^ $past(opSrc))
		&& statusFlags[aid_pkg::FLAG_N] == resultData[7]) else $error("exclusive or wrong");
	set_mask_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_07]
		exValid_reg && exOp_reg == aid_pkg::OP_SETM |=> resultData == ($past(opA) | $past(exImm_reg)))
		else $error("set bits wrong");
	clear_mask_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_08]
		exValid_reg && exOp_reg == aid_pkg::OP_CLRM |=> resultData == ($past(opA) & ~$past(exImm_reg)))
		else $error("clear bits wrong");
	test_keeps_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_09]
		exValid_reg && exOp_reg == aid_pkg::OP_TEST |=> resultData == $past(opA)
		&& statusFlags[aid_pkg::FLAG_Z] == ($past(opA) == 8'h00)) else $error("test changed value or z");
	bit_range_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_11]
		accept && isBit && ioIdx > aid_pkg::IO_BIT_LAST |=> state_reg == aid_pkg::ST_IDLE && ioRefused)
		else $error("high i/o index not refused");
	rmw_two_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_12]
		accept && isBit && bitOk |=> state_reg == aid_pkg::ST_WRITE && ioWrEn ##1 state_reg == aid_pkg::ST_IDLE)
		else $error("bit rewrite not two cycles");
	flags_update_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE_15]
		exValid_reg |=> statusFlags[7:6] == $past(status_reg[7:6]) && statusFlags[aid_pkg::FLAG_S]
		== $past(status_reg[aid_pkg::FLAG_S])) else $error("alu touched i t or s");
endmodule // aid_datapath

// ### design/aid_pkg.sv
// shared constants and types of the alu instruction datapath
package aid_pkg;
	// data and register file geometry
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned REG_COUNT = 32;
	localparam int unsigned REG_AW    = 5;
	localparam int unsigned APB_AW    = 8;
	// i/o register indices (byte address is four times the index)
	localparam logic [5:0] STATUS_IDX  = 6'h3f;
	localparam logic [5:0] IO_BIT_LAST = 6'h1f;
	localparam logic [5:0] EVENT_IDX   = 6'h05;
	localparam logic [5:0] SCRATCH_IDX = 6'h12;
	// values after reset and constant masks
	localparam logic [7:0] STATUS_RST  = 8'h00;
	localparam logic [7:0] EVENT_RST   = 8'h00;
	localparam logic [7:0] SCRATCH_RST = 8'h00;
	localparam logic [7:0] ALL_ONES    = 8'hff;
	// status flag positions, msb to lsb: i t h s v n z c
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_T = 6;
	localparam int unsigned FLAG_I = 7;
	// cycle counts
	localparam int unsigned ALU_CYCLES = 1;
	localparam int unsigned BIT_CYCLES = 2;
	// operations issued by the decoder
	typedef enum logic [3:0] {
		OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SUBTRACT_IMMEDIATE = 4'h3,
		OP_SBC = 4'h4, OP_SUBTRACT_IMMEDIATE_WITH_CARRY = 4'h5, OP_AND = 4'h6, OP_AND_IMMEDIATE = 4'h7,
		OP_OR = 4'h8, OP_ORI = 4'h9, OP_EOR = 4'ha, OP_SETM = 4'hb,
		OP_CLRM = 4'hc, OP_TEST = 4'hd, OP_IOSET = 4'he, OP_IOCLR = 4'hf
	} aid_op_t;
	// bit instruction sequencer
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_WRITE = 2'b10
	} aid_state_t;
endpackage

// ### design/aid_regfile.sv
// working register file: two registered read ports, one write port, write-first
`timescale 1ns/1ps
module aid_regfile #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32,
	parameter int unsigned AW    = 5
) (
	input  wire logic             clk,
	input  wire logic             wrEn,
	input  wire logic [AW-1:0]    wrAddr,
	input  wire logic [WIDTH-1:0] wrData,
	input  wire logic [AW-1:0]    rdAddrA,
	input  wire logic [AW-1:0]    rdAddrB,
	output logic      [WIDTH-1:0] rdDataA,
	output logic      [WIDTH-1:0] rdDataB
);
	if (DEPTH > (1 << AW) || WIDTH == 0) begin : g_chk
		$error("aid_regfile: depth does not fit the address width");
	end

	logic [WIDTH-1:0] mem [DEPTH];

	// write-first so a back-to-back dependent op sees the fresh value
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdDataA <= (wrEn && wrAddr == rdAddrA) ? wrData : mem[rdAddrA];
		rdDataB <= (wrEn && wrAddr == rdAddrB) ? wrData : mem[rdAddrB];
	end
endmodule // aid_regfile

// ### design/aid_io_space.sv
// low i/o space: write-one-to-clear event flags and a scratch register
`timescale 1ns/1ps
module aid_io_space (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       wrEn,
	input  wire logic [5:0] wrIdx,
	input  wire logic [7:0] wrData,
	input  wire logic [7:0] eventIn,
	input  wire logic [5:0] rdIdxA,
	input  wire logic [5:0] rdIdxB,
	output logic      [7:0] rdDataA,
	output logic      [7:0] rdDataB,
	output logic      [7:0] scratchOut
);
	logic [7:0] event_reg;
	logic [7:0] scratch_reg;

	function automatic logic [7:0] ioRead(input logic [5:0] idx, input logic [7:0] ev, sc);
		ioRead = (idx == aid_pkg::EVENT_IDX) ? ev : (idx == aid_pkg::SCRATCH_IDX) ? sc : 8'h00;
	endfunction

	// one clears, zero keeps; a new event in the clearing cycle still sets
	always_ff @(posedge clk) begin
		if (!nrst) begin
			event_reg <= aid_pkg::EVENT_RST;
		end else begin
			event_reg <= (event_reg & ~((wrEn && wrIdx == aid_pkg::EVENT_IDX) ? wrData : 8'h00)) | eventIn; // [RULE_10]
		end
	end

	// plain read-write register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			scratch_reg <= aid_pkg::SCRATCH_RST;
		end else if (wrEn && wrIdx == aid_pkg::SCRATCH_IDX) begin
			scratch_reg <= wrData;
		end
	end

	assign rdDataA    = ioRead(rdIdxA, event_reg, scratch_reg);
	assign rdDataB    = ioRead(rdIdxB, event_reg, scratch_reg);
	assign scratchOut = scratch_reg;
endmodule // aid_io_space

// ### dv/aid_decoder_model.sv
// decoder model: offers one operation and holds it until the datapath takes it
`timescale 1ns/1ps
module aid_decoder_model (
	input  wire logic       clk,
	input  wire logic       opReady,
	output logic            opValid,
	output logic      [3:0] opCode,
	output logic      [4:0] dstIdx,
	output logic      [4:0] srcIdx,
	output logic      [7:0] immValue,
	output logic      [5:0] ioIdx,
	output logic      [2:0] bitSel
);
	// quiet fields at time zero
	initial begin
		opValid = 1'b0;
		{opCode, dstIdx, srcIdx, immValue, ioIdx, bitSel} = '0;
	end
	// called just after an edge; held until the edge that sees opReady high
	task automatic issue(input logic [3:0] c, input logic [4:0] d, input logic [4:0] s,
		input logic [7:0] k, input logic [5:0] io, input logic [2:0] b);
		opValid  <= 1'b1;
		opCode   <= c;
		dstIdx   <= d;
		srcIdx   <= s;
		immValue <= k;
		ioIdx    <= io;
		bitSel   <= b;
		do @(posedge clk); while (opReady !== 1'b1);
	endtask
	// idle fields flip so a stale operand is never trusted
	task automatic rest();
		opValid  <= 1'b0;
		immValue <= ~immValue;
		srcIdx   <= ~srcIdx;
	endtask
endmodule // aid_decoder_model

// ### dv/aid_datapath_test.sv
// self-checking bench of the alu datapath: random and corner ops, apb and i/o bit ops
`timescale 1ns/1ps
module aid_datapath_test;
	logic        clk, nrst, opValid, opReady, resultValid, ioRefused;
	logic        psel, penable, pwrite, pready, pslverr, e;
	logic [3:0]  opCode;
	logic [4:0]  dstIdx, srcIdx, resultDst;
	logic [7:0]  immValue, resultData, statusFlags, eventIn, scratchOut, paddr, v;
	logic [5:0]  ioIdx;
	logic [2:0]  bitSel;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  regs [32];
	logic [7:0]  flags;
	logic [20:0] expq [$];
	logic [20:0] ex;
	logic [7:0]  mapA [3] = '{8'hfc, 8'h14, 8'h48};
	int          n_errors = 0;
	int          total_checks = 0;

	aid_datapath #(.REG_COUNT(aid_pkg::REG_COUNT)) i_aid_datapath (.clk(clk), .nrst(nrst), .opValid(opValid),
		.opReady(opReady), .opCode(opCode), .dstIdx(dstIdx), .srcIdx(srcIdx), .immValue(immValue),
		.ioIdx(ioIdx), .bitSel(bitSel), .resultValid(resultValid), .resultDst(resultDst),
		.resultData(resultData), .ioRefused(ioRefused), .statusFlags(statusFlags), .eventIn(eventIn),
		.scratchOut(scratchOut), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	aid_decoder_model i_aid_decoder_model (.clk(clk), .opReady(opReady), .opValid(opValid), .opCode(opCode),
		.dstIdx(dstIdx), .srcIdx(srcIdx), .immValue(immValue), .ioIdx(ioIdx), .bitSel(bitSel));

	// free-running core clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// reference: {flags, result}; s t i never touched, logic ops clear v
	function automatic logic [15:0] refOp(input logic [3:0] c, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] f);
		logic [8:0] w;
		logic [4:0] hw;
		logic       ci;
		ci = (c == aid_pkg::OP_ADC || c == aid_pkg::OP_SBC || c == aid_pkg::OP_SUBTRACT_IMMEDIATE_WITH_CARRY) & f[0];
		if (c <= aid_pkg::OP_ADC) begin
			w = a + b + ci;
			hw = a[3:0] + b[3:0] + ci;
			f[3] = (a[7] == b[7]) && (w[7] != a[7]);
		end else if (c <= aid_pkg::OP_SUBTRACT_IMMEDIATE_WITH_CARRY) begin
			w = {1'b0, a} - b - ci;
			hw = {1'b0, a[3:0]} - b[3:0] - ci;
			f[3] = (a[7] != b[7]) && (w[7] != a[7]);
		end else begin
			case (c)
				aid_pkg::OP_OR, aid_pkg::OP_ORI, aid_pkg::OP_SETM: w = {1'b0, a | b};
				aid_pkg::OP_EOR: w = {1'b0, a ^ b};
				aid_pkg::OP_CLRM: w = {1'b0, a & (aid_pkg::ALL_ONES - b)};
				default: w = {1'b0, a & b};
			endcase
			f[3] = 1'b0;
		end
		if (c <= aid_pkg::OP_SUBTRACT_IMMEDIATE_WITH_CARRY) begin
			f[0] = w[8];
			f[5] = hw[4];
		end
		f[1] = (w[7:0] == 8'h00);
		f[2] = w[7];
		return {f, w[7:0]};
	endfunction

	// models the op, queues the answer and hands it to the decoder model
	task automatic alu(input logic [3:0] c, input logic [4:0] d, input logic [4:0] s, input logic [7:0] k);
		logic [7:0]  b;
		logic [15:0] x;
		b = (c inside {4'h3, 4'h5, 4'h7, 4'h9, 4'hb, 4'hc}) ? k : (c == aid_pkg::OP_TEST ? regs[d] : regs[s]);
		x = refOp(c, regs[d], b, flags);
		regs[d] = x[7:0];
		flags = x[15:8];
		expq.push_back({d, x});
		i_aid_decoder_model.issue(c, d, s, k, 6'h00, 3'h0);
	endtask

	task automatic drain();
		i_aid_decoder_model.rest();
		repeat (3) @(posedge clk);
		check("pending results", expq.size(), 0);
	endtask

	// apb master: setup, then access held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~wd;
	endtask

	task automatic bitop(input logic [3:0] c, input logic [5:0] idx, input logic [2:0] b, input logic refuse);
		i_aid_decoder_model.issue(c, 5'h00, 5'h00, 8'h00, idx, b);
		i_aid_decoder_model.rest();
		@(negedge clk);
		check("ioRefused", ioRefused, refuse);
		check("opReady", opReady, refuse);
		@(posedge clk);
	endtask

	// results leave in issue order, one per alu op
	always @(negedge clk) begin
		if (resultValid === 1'b1) begin
			check("result queued", expq.size() != 0, 1'b1);
			if (expq.size() > 0) begin
				ex = expq.pop_front();
				check("resultDst", resultDst, ex[20:16]);
				check("resultData", resultData, ex[7:0]);
				check("statusFlags", statusFlags, ex[15:8]);
			end
		end
	end

	// hang guard, far beyond the expected run
	initial begin
		#2000000;
		n_errors++;
		wrap_up();
	end

	initial begin
		void'($urandom(41722));
		{nrst, psel, penable, pwrite, paddr, pwdata, eventIn} = '0;
		flags = aid_pkg::STATUS_RST;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		check("status after reset", statusFlags, aid_pkg::STATUS_RST);
		check("outputs after reset", {resultValid, ioRefused, opReady, resultDst, resultData, scratchOut},
			{3'b001, 5'h00, 8'h00, 8'h00});
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, mapA[i], 32'h0);
			check("reset value", rd, 32'h0);
			check("mapped pslverr", e, 1'b0);
		end
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped read", rd, 32'h0);
		check("unmapped pslverr", e, 1'b1);
		// registers start unknown: clearing by a full mask brings each one to a known value
		for (int i = 0; i < 32; i++) begin
			alu(aid_pkg::OP_CLRM, i[4:0], 5'h00, 8'hff);
			alu(aid_pkg::OP_ORI, i[4:0], 5'h00, 8'($urandom));
		end
		drain();
		alu(aid_pkg::OP_ORI, 5'h03, 5'h00, 8'h80);
		// nothing in flight, so the lone add shows its own pulse only
		drain();
		alu(aid_pkg::OP_ADD, 5'h03, 5'h03, 8'h00);
		i_aid_decoder_model.rest();
		@(negedge clk);
		check("one cycle after take", resultValid, 1'b0);
		@(negedge clk);
		check("answer cycle", resultValid, 1'b1);
		@(negedge clk);
		check("pulse ends", resultValid, 1'b0);
		drain();
		for (int n = 0; n < 300; n++) begin
			if (n % 60 == 0) begin
				drain();
				v = 8'($urandom);
				apb(1'b1, 8'hfc, {24'h0, v});
				flags = v;
				apb(1'b0, 8'hfc, 32'h0);
				check("status readback", rd, {24'h0, v});
			end
			alu(4'($urandom_range(0, 13)), 5'($urandom), 5'($urandom), 8'($urandom));
		end
		drain();
		for (int b = 0; b < 8; b++) begin
			v = 8'($urandom);
			apb(1'b1, 8'h48, {24'h0, v});
			bitop(b[0] ? aid_pkg::OP_IOCLR : aid_pkg::OP_IOSET, aid_pkg::SCRATCH_IDX, b[2:0], 1'b0);
			@(negedge clk);
			check("scratchOut", scratchOut, b[0] ? v & ~(8'h01 << b) : v | (8'h01 << b));
		end
		bitop(aid_pkg::OP_IOSET, aid_pkg::STATUS_IDX, 3'h0, 1'b1);
		bitop(aid_pkg::OP_IOCLR, 6'h20, 3'h3, 1'b1);
		check("status untouched", statusFlags, flags);
		eventIn <= 8'ha5;
		@(posedge clk);
		eventIn <= 8'h00;
		apb(1'b0, 8'h14, 32'h0);
		check("event flags", rd, 32'ha5);
		bitop(aid_pkg::OP_IOCLR, aid_pkg::EVENT_IDX, 3'h0, 1'b0);
		apb(1'b0, 8'h14, 32'h0);
		check("event after bit clear", rd, 32'h01);
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		check("event kept on zero", rd, 32'h01);
		apb(1'b1, 8'h14, 32'h01);
		apb(1'b0, 8'h14, 32'h0);
		check("event cleared on one", rd, 32'h00);
		eventIn <= 8'h30;
		@(posedge clk);
		eventIn <= 8'h00;
		bitop(aid_pkg::OP_IOSET, aid_pkg::EVENT_IDX, 3'h7, 1'b0);
		apb(1'b0, 8'h14, 32'h0);
		check("event after bit set", rd, 32'h00);
		wrap_up();
	end
endmodule // aid_datapath_test
